// >>> hdl/fsmc_params.svh
`ifndef FSMC_PARAMS_SVH
`define FSMC_PARAMS_SVH

// register offsets
`define FSMC_ADDR_X_HIGH      8'h00
`define FSMC_ADDR_X_MID       8'h01
`define FSMC_ADDR_Y_HIGH      8'h02
`define FSMC_ADDR_Y_MID       8'h03
`define FSMC_ADDR_Z_HIGH      8'h04
`define FSMC_ADDR_Z_MID       8'h05
`define FSMC_ADDR_LOW_BITS    8'h06
`define FSMC_ADDR_TEMP        8'h07
`define FSMC_ADDR_STATUS      8'h08
`define FSMC_ADDR_COMMAND     8'h09

// status bits
`define FSMC_ST_FIELD_DONE    0
`define FSMC_ST_TEMP_DONE     1
`define FSMC_ST_TRIM_DONE     4
`define FSMC_STATUS_RESET     8'h00

// command bits
`define FSMC_CMD_FIELD        0
`define FSMC_CMD_TEMP         1
`define FSMC_CMD_INT_EN       2
`define FSMC_CMD_SET_PULSE    3
`define FSMC_CMD_REV_PULSE    4
`define FSMC_CMD_AUTO_PULSE   5
`define FSMC_CMD_TRIM         6
`define FSMC_CMD_RESET        8'h00
`define FSMC_CMD_PULSE_MASK   8'h5B
`define FSMC_CMD_LEVEL_MASK   8'h24

// timing
`define FSMC_CLK_PERIOD_NS    100
`define FSMC_COIL_PULSE_NS    500
`define FSMC_COIL_CYC         ((`FSMC_COIL_PULSE_NS + `FSMC_CLK_PERIOD_NS - 1) / `FSMC_CLK_PERIOD_NS)
`define FSMC_MEAS_BW0_US      8000
`define FSMC_MEAS_BW1_US      4000
`define FSMC_MEAS_BW2_US      2000
`define FSMC_MEAS_BW3_US      500
`define FSMC_US_TO_CYC(us)    (((us) * 1000) / `FSMC_CLK_PERIOD_NS)

`endif

// >>> hdl/fsmc_pkg.sv
package fsmc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_COIL = 4'h2,
    ST_MEAS = 4'h4,
    ST_TRIM = 4'h8
  } fsmc_state_t;

  typedef struct packed {
    logic [17:0] x;
    logic [17:0] y;
    logic [17:0] z;
    logic [7:0]  temp;
  } fsmc_sample_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
  } fsmc_reg_req_t;

endpackage

// >>> hdl/fsmc_cycle_timer.sv
`timescale 1ns/1ps

module fsmc_cycle_timer #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // control
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  // status
  output logic              busy,
  output logic              done
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  if (W < 2 || W > 24) begin : g_chk
    $error("fsmc_cycle_timer: W out of range");
  end

  // busy for exactly load cycles, done on the last of them
  always_comb begin
    count_next = count_reg;
    if (start) begin
      count_next = load;
    end else if (count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy = (count_reg != '0);
  assign done = (count_reg == W'(1)) && !start;

endmodule // fsmc_cycle_timer

// >>> hdl/fsmc_top.sv
`timescale 1ns/1ps
`include "fsmc_params.svh"

module fsmc_top #(
  parameter int unsigned MEAS_CYC_BW0 = `FSMC_US_TO_CYC(`FSMC_MEAS_BW0_US),
  parameter int unsigned MEAS_CYC_BW1 = `FSMC_US_TO_CYC(`FSMC_MEAS_BW1_US),
  parameter int unsigned MEAS_CYC_BW2 = `FSMC_US_TO_CYC(`FSMC_MEAS_BW2_US),
  parameter int unsigned MEAS_CYC_BW3 = `FSMC_US_TO_CYC(`FSMC_MEAS_BW3_US),
  parameter int unsigned TIMER_W      = 17
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // register port
  input  wire fsmc_pkg::fsmc_reg_req_t reg_req,
  output logic [7:0]                   reg_rd_data,
  output logic                         reg_rd_valid,
  // bandwidth selection
  input  wire logic                    bandwidth_sel_hi,
  input  wire logic                    bandwidth_sel_lo,
  // converter front end
  input  wire fsmc_pkg::fsmc_sample_t  afe_sample,
  output logic                         afe_field_convert,
  output logic                         afe_temp_convert,
  // polarity coils
  output logic                         coil_set_drive,
  output logic                         coil_reset_drive,
  // trim memory
  output logic                         otp_load_req,
  input  wire logic                    otp_load_done,
  input  wire logic                    otp_load_ok,
  // interrupt pin
  output logic                         int_out,
  output logic                         int_out_en
);
  import fsmc_pkg::*;

  localparam int unsigned COIL_W = 4;

  if (TIMER_W > 24 || MEAS_CYC_BW0 < 1 || MEAS_CYC_BW3 < 1 ||
      MEAS_CYC_BW0 >= (1 << TIMER_W) || MEAS_CYC_BW1 >= (1 << TIMER_W) ||
      MEAS_CYC_BW2 >= (1 << TIMER_W) || MEAS_CYC_BW3 >= (1 << TIMER_W) ||
      `FSMC_COIL_CYC >= (1 << COIL_W)) begin : g_chk
    $error("fsmc_top: timer width too small for counts");
  end

  fsmc_state_t  state_reg;
  fsmc_state_t  state_next;
  logic [7:0]   cmd_reg;
  logic [7:0]   cmd_next;
  logic         chain_reg;
  logic         chain_next;
  logic         pol_rev_reg;
  logic         pol_rev_next;
  logic         meas_temp_reg;
  logic         meas_temp_next;
  logic         field_done_reg;
  logic         field_done_next;
  logic         temp_done_reg;
  logic         temp_done_next;
  logic         trim_done_reg;
  logic         trim_done_next;
  logic         pend_f_reg;
  logic         pend_f_next;
  logic         pend_t_reg;
  logic         pend_t_next;
  logic         int_out_reg;
  logic         int_out_next;
  fsmc_sample_t sample_reg;
  fsmc_sample_t sample_next;
  logic [7:0]   rd_data_reg;
  logic [7:0]   rd_data_next;
  logic         rd_valid_reg;

  logic               cmd_wr;
  logic               st_wr;
  logic               coil_start;
  logic               coil_busy;
  logic               coil_done;
  logic               meas_start;
  logic               meas_busy;
  logic               meas_done;
  logic               end_field;
  logic               end_temp;
  logic               end_trim;
  logic [TIMER_W-1:0] meas_load;

  assign cmd_wr    = reg_req.wr_en && (reg_req.addr == `FSMC_ADDR_COMMAND);
  assign st_wr     = reg_req.wr_en && (reg_req.addr == `FSMC_ADDR_STATUS);
  assign end_field = (state_reg == ST_MEAS) && meas_done && !meas_temp_reg;
  assign end_temp  = (state_reg == ST_MEAS) && meas_done && meas_temp_reg;
  assign end_trim  = (state_reg == ST_TRIM) && otp_load_done;

  // conversion length follows the bandwidth code
  always_comb begin
    case ({bandwidth_sel_hi, bandwidth_sel_lo})
      2'h0:    meas_load = TIMER_W'(MEAS_CYC_BW0);
      2'h1:    meas_load = TIMER_W'(MEAS_CYC_BW1);
      2'h2:    meas_load = TIMER_W'(MEAS_CYC_BW2);
      default: meas_load = TIMER_W'(MEAS_CYC_BW3);
    endcase
  end

  fsmc_cycle_timer #(
    .W (COIL_W)
  ) u_coil_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (coil_start),
    .load    (COIL_W'(`FSMC_COIL_CYC)),
    .busy    (coil_busy),
    .done    (coil_done)
  );

  fsmc_cycle_timer #(
    .W (TIMER_W)
  ) u_meas_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (meas_start),
    .load    (meas_load),
    .busy    (meas_busy),
    .done    (meas_done)
  );

  // sequencer: trim first, then coil pulses, then conversions
  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    chain_next     = chain_reg;
    pol_rev_next   = pol_rev_reg;
    meas_temp_next = meas_temp_reg;
    coil_start     = 1'b0;
    meas_start     = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_reg[`FSMC_CMD_TRIM]) begin
          state_next = ST_TRIM;
        end else if (cmd_reg[`FSMC_CMD_SET_PULSE] || cmd_reg[`FSMC_CMD_REV_PULSE]) begin
          state_next   = ST_COIL;
          coil_start   = 1'b1;
          chain_next   = 1'b0;
          pol_rev_next = !cmd_reg[`FSMC_CMD_SET_PULSE];
        end else if (cmd_reg[`FSMC_CMD_FIELD]) begin
          meas_temp_next = 1'b0;
          if (cmd_reg[`FSMC_CMD_AUTO_PULSE]) begin
            state_next   = ST_COIL;
            coil_start   = 1'b1;
            chain_next   = 1'b1;
            pol_rev_next = 1'b0;
          end else begin
            state_next = ST_MEAS;
            meas_start = 1'b1;
          end
        end else if (cmd_reg[`FSMC_CMD_TEMP]) begin
          state_next     = ST_MEAS;
          meas_start     = 1'b1;
          meas_temp_next = 1'b1;
        end
      end
      ST_COIL: begin
        if (coil_done) begin
          if (chain_reg) begin
            state_next = ST_MEAS;
            meas_start = 1'b1;
            chain_next = 1'b0;
          end else begin
            state_next = ST_IDLE;
            cmd_next[pol_rev_reg ? `FSMC_CMD_REV_PULSE : `FSMC_CMD_SET_PULSE] = 1'b0;
          end
        end
      end
      ST_MEAS: begin
        if (meas_done) begin
          state_next = ST_IDLE;
          cmd_next[meas_temp_reg ? `FSMC_CMD_TEMP : `FSMC_CMD_FIELD] = 1'b0;
        end
      end
      ST_TRIM: begin
        if (otp_load_done) begin
          state_next              = ST_IDLE;
          cmd_next[`FSMC_CMD_TRIM] = 1'b0;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // a host write landing with a self-clear still starts a new command
    if (cmd_wr) begin
      cmd_next = (cmd_next & ~`FSMC_CMD_LEVEL_MASK) |
                 (reg_req.wr_data & (`FSMC_CMD_LEVEL_MASK | `FSMC_CMD_PULSE_MASK));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= ST_IDLE;
      cmd_reg       <= `FSMC_CMD_RESET;
      chain_reg     <= 1'b0;
      pol_rev_reg   <= 1'b0;
      meas_temp_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      chain_reg     <= chain_next;
      pol_rev_reg   <= pol_rev_next;
      meas_temp_reg <= meas_temp_next;
    end
  end

  // status flags and interrupt; a set always beats a clear
  always_comb begin
    field_done_next = field_done_reg;
    temp_done_next  = temp_done_reg;
    trim_done_next  = trim_done_reg;
    pend_f_next     = pend_f_reg;
    pend_t_next     = pend_t_reg;
    if (cmd_wr && reg_req.wr_data[`FSMC_CMD_FIELD]) begin
      field_done_next = 1'b0;
    end
    if (cmd_wr && reg_req.wr_data[`FSMC_CMD_TEMP]) begin
      temp_done_next = 1'b0;
    end
    if (st_wr && reg_req.wr_data[`FSMC_ST_FIELD_DONE]) begin
      pend_f_next = 1'b0;
    end
    if (st_wr && reg_req.wr_data[`FSMC_ST_TEMP_DONE]) begin
      pend_t_next = 1'b0;
    end
    if (end_field) begin
      field_done_next = 1'b1;
      pend_f_next     = pend_f_next | cmd_reg[`FSMC_CMD_INT_EN];
    end
    if (end_temp) begin
      temp_done_next = 1'b1;
      pend_t_next    = pend_t_next | cmd_reg[`FSMC_CMD_INT_EN];
    end
    if (end_trim) begin
      trim_done_next = otp_load_ok;
    end
    int_out_next = cmd_reg[`FSMC_CMD_INT_EN] && (pend_f_reg || pend_t_reg);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      field_done_reg <= 1'b0;
      temp_done_reg  <= 1'b0;
      trim_done_reg  <= 1'b0;
      pend_f_reg     <= 1'b0;
      pend_t_reg     <= 1'b0;
      int_out_reg    <= 1'b0;
    end else begin
      field_done_reg <= field_done_next;
      temp_done_reg  <= temp_done_next;
      trim_done_reg  <= trim_done_next;
      pend_f_reg     <= pend_f_next;
      pend_t_reg     <= pend_t_next;
      int_out_reg    <= int_out_next;
    end
  end

  // results land on the same edge as the done flag, so a poll is coherent
  always_comb begin
    sample_next = sample_reg;
    if (end_field) begin
      sample_next.x = afe_sample.x;
      sample_next.y = afe_sample.y;
      sample_next.z = afe_sample.z;
    end
    if (end_temp) begin
      sample_next.temp = afe_sample.temp;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_reg <= '0;
    end else begin
      sample_reg <= sample_next;
    end
  end

  // read mux; command register and unmapped offsets read zero
  always_comb begin
    rd_data_next = rd_data_reg;
    if (reg_req.rd_en) begin
      if (reg_req.addr == `FSMC_ADDR_X_HIGH) begin
        rd_data_next = sample_reg.x[17:10];
      end else if (reg_req.addr == `FSMC_ADDR_X_MID) begin
        rd_data_next = sample_reg.x[9:2];
      end else if (reg_req.addr == `FSMC_ADDR_Y_HIGH) begin
        rd_data_next = sample_reg.y[17:10];
      end else if (reg_req.addr == `FSMC_ADDR_Y_MID) begin
        rd_data_next = sample_reg.y[9:2];
      end else if (reg_req.addr == `FSMC_ADDR_Z_HIGH) begin
        rd_data_next = sample_reg.z[17:10];
      end else if (reg_req.addr == `FSMC_ADDR_Z_MID) begin
        rd_data_next = sample_reg.z[9:2];
      end else if (reg_req.addr == `FSMC_ADDR_LOW_BITS) begin
        rd_data_next = {sample_reg.x[1:0], sample_reg.y[1:0], sample_reg.z[1:0], 2'h0};
      end else if (reg_req.addr == `FSMC_ADDR_TEMP) begin
        rd_data_next = sample_reg.temp;
      end else if (reg_req.addr == `FSMC_ADDR_STATUS) begin
        rd_data_next = `FSMC_STATUS_RESET;
        rd_data_next[`FSMC_ST_FIELD_DONE] = field_done_reg;
        rd_data_next[`FSMC_ST_TEMP_DONE]  = temp_done_reg;
        rd_data_next[`FSMC_ST_TRIM_DONE]  = trim_done_reg;
      end else begin
        rd_data_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= reg_req.rd_en;
    end
  end

  assign reg_rd_data       = rd_data_reg;
  assign reg_rd_valid      = rd_valid_reg;
  assign afe_field_convert = (state_reg == ST_MEAS) && !meas_temp_reg && meas_busy;
  assign afe_temp_convert  = (state_reg == ST_MEAS) && meas_temp_reg && meas_busy;
  assign coil_set_drive    = (state_reg == ST_COIL) && !pol_rev_reg && coil_busy;
  assign coil_reset_drive  = (state_reg == ST_COIL) && pol_rev_reg && coil_busy;
  assign otp_load_req      = (state_reg == ST_TRIM);
  assign int_out           = int_out_reg;
  assign int_out_en        = cmd_reg[`FSMC_CMD_INT_EN];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_set_pulse;
    coil_set_drive [*5] ##1 !coil_set_drive;
  endsequence

  property p_field_clear;
    cmd_wr && reg_req.wr_data[`FSMC_CMD_FIELD] && !end_field |=> !field_done_reg;
  endproperty
  a_field_clear: assert property (p_field_clear) else $error("field done not cleared");

  property p_field_end;
    end_field |=> field_done_reg && !cmd_reg[`FSMC_CMD_FIELD] &&
                  sample_reg.y == $past(afe_sample.y) && sample_reg.z == $past(afe_sample.z);
  endproperty
  a_field_end: assert property (p_field_end) else $error("field end not coherent");

  property p_temp_end;
    end_temp |=> temp_done_reg && sample_reg.temp == $past(afe_sample.temp);
  endproperty
  a_temp_end: assert property (p_temp_end) else $error("temp end wrong");

  property p_int_clear;
    st_wr && reg_req.wr_data[`FSMC_ST_FIELD_DONE] && !end_field |=> !pend_f_reg;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared");

  property p_set_width;
    $rose(coil_set_drive) |-> s_set_pulse;
  endproperty
  a_set_width: assert property (p_set_width) else $error("set pulse width wrong");

  property p_rev_width;
    $rose(coil_reset_drive) |-> coil_reset_drive [*5] ##1 !coil_reset_drive;
  endproperty
  a_rev_width: assert property (p_rev_width) else $error("reverse pulse width wrong");

  property p_int_pin;
    int_out_en && (pend_f_reg || pend_t_reg) |=> int_out;
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("interrupt not raised");

  property p_int_hiz;
    !int_out_en |-> !int_out ##1 !int_out;
  endproperty
  a_int_hiz: assert property (p_int_hiz) else $error("interrupt driven while off");

  property p_low_read;
    reg_req.rd_en && reg_req.addr == `FSMC_ADDR_LOW_BITS |=>
      reg_rd_data == {$past(sample_reg.x[1:0]), $past(sample_reg.y[1:0]),
                      $past(sample_reg.z[1:0]), 2'h0};
  endproperty
  a_low_read: assert property (p_low_read) else $error("low bits read wrong");

  property p_trim;
    end_trim |=> trim_done_reg == $past(otp_load_ok) && !cmd_reg[`FSMC_CMD_TRIM] ||
                 $past(cmd_wr);
  endproperty
  a_trim: assert property (p_trim) else $error("trim done wrong");

endmodule // fsmc_top

// >>> bench/fsmc_far_model.sv
`timescale 1ns/1ps

module fsmc_far_model (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // converter front end
  input  wire logic                   afe_field_convert,
  input  wire logic                   afe_temp_convert,
  input  wire fsmc_pkg::fsmc_sample_t sample_in,
  output fsmc_pkg::fsmc_sample_t      afe_sample,
  // trim memory
  input  wire logic                   otp_load_req,
  input  wire logic [3:0]             otp_delay,
  input  wire logic                   otp_ok_in,
  output logic                        otp_load_done,
  output logic                        otp_load_ok
);
  import fsmc_pkg::*;
  logic [3:0]  wait_reg;
  logic [61:0] noise_reg;

  // lines wander outside a conversion, so a capture at the wrong cycle shows
  assign afe_sample = (afe_field_convert || afe_temp_convert) ? sample_in
                                                             : fsmc_sample_t'(noise_reg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg      <= 4'h0;
      noise_reg     <= '0;
      otp_load_done <= 1'b0;
      otp_load_ok   <= 1'b0;
    end else begin
      noise_reg <= {noise_reg[60:0], ~noise_reg[61]};
      if (otp_load_req && !otp_load_done && wait_reg == otp_delay) begin
        otp_load_done <= 1'b1;
        otp_load_ok   <= otp_ok_in;
        wait_reg      <= 4'h0;
      end else begin
        otp_load_done <= 1'b0;
        wait_reg      <= (otp_load_req && !otp_load_done) ? wait_reg + 4'h1 : 4'h0;
      end
    end
  end
endmodule // fsmc_far_model

// >>> bench/fsmc_top_tb.sv
`timescale 1ns/1ps

module fsmc_top_tb;
  import fsmc_pkg::*;
  logic          clk;
  logic          reset_n;
  fsmc_reg_req_t req;
  logic [7:0]    reg_rd_data;
  logic          reg_rd_valid;
  logic          bandwidth_sel_hi;
  logic          bandwidth_sel_lo;
  fsmc_sample_t  afe_sample;
  fsmc_sample_t  sample_in;
  logic          afe_field_convert;
  logic          afe_temp_convert;
  logic          coil_set_drive;
  logic          coil_reset_drive;
  logic          otp_load_req;
  logic          otp_load_done;
  logic          otp_load_ok;
  logic          otp_ok_in;
  logic [3:0]    otp_delay;
  logic          int_out;
  logic          int_out_en;
  logic [7:0]    n_conv, n_temp, n_set, n_rev, n_otp;
  logic [7:0]    exp_st;
  logic [7:0]    d;
  logic [7:0]    cmd;
  int            seed;
  int            n_errors;
  int            checks;
  int            i;

  fsmc_top #(.MEAS_CYC_BW0(20), .MEAS_CYC_BW1(15), .MEAS_CYC_BW2(10), .MEAS_CYC_BW3(6))
  fsmc_top_inst (.clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .bandwidth_sel_hi(bandwidth_sel_hi),
    .bandwidth_sel_lo(bandwidth_sel_lo), .afe_sample(afe_sample),
    .afe_field_convert(afe_field_convert), .afe_temp_convert(afe_temp_convert),
    .coil_set_drive(coil_set_drive), .coil_reset_drive(coil_reset_drive),
    .otp_load_req(otp_load_req), .otp_load_done(otp_load_done), .otp_load_ok(otp_load_ok),
    .int_out(int_out), .int_out_en(int_out_en));

  fsmc_far_model fsmc_far_model_inst (.clk(clk), .reset_n(reset_n),
    .afe_field_convert(afe_field_convert), .afe_temp_convert(afe_temp_convert),
    .sample_in(sample_in), .afe_sample(afe_sample), .otp_load_req(otp_load_req),
    .otp_delay(otp_delay), .otp_ok_in(otp_ok_in), .otp_load_done(otp_load_done),
    .otp_load_ok(otp_load_ok));

  always #50 clk = ~clk;

  // cycle counts of the convert, coil drive and trim request outputs, zeroed by the sequence before each step
  always @(posedge clk) begin
    n_conv = n_conv + {7'h00, afe_field_convert};
    n_temp = n_temp + {7'h00, afe_temp_convert};
    n_set  = n_set + {7'h00, coil_set_drive};
    n_rev  = n_rev + {7'h00, coil_reset_drive};
    n_otp  = n_otp + {7'h00, otp_load_req};
  end

  function automatic logic [7:0] conv_len(input logic [1:0] bw);
    case (bw)
      2'b00: return 8'h14;
      2'b01: return 8'h0f;
      2'b10: return 8'h0a;
      default: return 8'h06;
    endcase
  endfunction

  function automatic logic [7:0] exp_byte(input logic [2:0] a, input fsmc_sample_t s);
    case (a)
      3'h0: return s.x[17:10];
      3'h1: return s.x[9:2];
      3'h2: return s.y[17:10];
      3'h3: return s.y[9:2];
      3'h4: return s.z[17:10];
      3'h5: return s.z[9:2];
      3'h6: return {s.x[1:0], s.y[1:0], s.z[1:0], 2'b00};
      default: return s.temp;
    endcase
  endfunction

  task automatic end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // strobes are one cycle wide and never re-raised in the same time step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req.wr_en   = 1'b1;
    req.addr    = a;
    req.wr_data = v;
    tick(1);
    req.wr_en = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    req.rd_en = 1'b1;
    req.addr  = a;
    tick(1);
    req.rd_en = 1'b0;
    check(8'(reg_rd_valid), 8'h01);
    v = reg_rd_data;
    tick(1);
  endtask

  task automatic wait_done(input int b);
    logic [7:0] s;
    for (int k = 0; k < 100; k++) begin
      rd(8'h08, s);
      if (s[b] === 1'b1) return;
    end
    check(8'h00, 8'h01);
    end_sim;
  endtask

  task automatic run_field(input logic [1:0] bw, input logic corner);
    logic [63:0] r;
    logic [7:0]  v;
    r = {$random(seed), $random(seed)};
    sample_in = corner ? fsmc_sample_t'({62{1'b1}}) : fsmc_sample_t'(r[61:0]);
    {bandwidth_sel_hi, bandwidth_sel_lo} = bw;
    n_conv = 8'h00;
    n_set = 8'h00;
    wr(8'h09, {2'b00, bw[0], 5'h05});
    rd(8'h08, v);
    check(8'(v[0]), 8'h00);
    wait_done(0);
    exp_st[0] = 1'b1;
    check(n_conv, conv_len(bw));
    check(n_set, bw[0] ? 8'h05 : 8'h00);
    for (int a = 0; a < 7; a++) begin
      rd(8'(a), v);
      check(v, exp_byte(3'(a), sample_in));
    end
    check(8'({int_out_en, int_out}), 8'h03);
    wr(8'h08, 8'h00);
    check(8'(int_out), 8'h01);
    wr(8'h08, 8'h01);
    tick(1);
    check(8'(int_out), 8'h00);
    rd(8'h08, v);
    check(v, exp_st);
  endtask

  initial begin
    seed = 32'hb9ae_43bc;
    clk = 1'b0;
    reset_n = 1'b0;
    req = '0;
    {bandwidth_sel_hi, bandwidth_sel_lo} = 2'b00;
    sample_in = '0;
    otp_ok_in = 1'b1;
    otp_delay = 4'h0;
    exp_st = 8'h00;
    {n_conv, n_temp, n_set, n_rev, n_otp} = '0;
    n_errors = 0;
    checks = 0;
    tick(5);
    reset_n = 1'b1;
    tick(1);
    rd(8'h08, d);
    check(d, 8'h00);
    rd(8'h09, d);
    check(d, 8'h00);
    rd(8'h0a, d);
    check(d, 8'h00);
    check(8'(int_out_en), 8'h00);
    wr(8'h02, 8'hff);
    wr(8'h09, 8'h04);
    check(8'(int_out_en), 8'h01);
    for (int b = 0; b < 4; b++) begin
      run_field(2'(b), b == 0);
    end
    // temperature conversion leaves the field flag standing; second round sees the clear
    for (int t = 0; t < 2; t++) begin
      sample_in = fsmc_sample_t'(62'({$random(seed), $random(seed)}));
      n_temp = 8'h00;
      wr(8'h09, 8'h06);
      rd(8'h08, d);
      check(8'(d[1]), 8'h00);
      wait_done(1);
      exp_st[1] = 1'b1;
      check(n_temp, 8'h06);
      rd(8'h07, d);
      check(d, sample_in.temp);
      rd(8'h08, d);
      check(d, exp_st);
      check(8'(int_out), 8'h01);
      wr(8'h08, 8'h02);
      tick(1);
      check(8'(int_out), 8'h00);
    end
    // set, reverse, then both back to back
    for (int k = 1; k < 4; k++) begin
      cmd = {3'b000, 2'(k), 3'b100};
      n_set = 8'h00;
      n_rev = 8'h00;
      wr(8'h09, cmd);
      tick(20);
      check(n_set, cmd[3] ? 8'h05 : 8'h00);
      check(n_rev, cmd[4] ? 8'h05 : 8'h00);
    end
    // prompt good reload, then slow failed one
    for (int k = 0; k < 2; k++) begin
      otp_ok_in = (k == 0);
      otp_delay = k ? 4'h9 : 4'h0;
      n_otp = 8'h00;
      wr(8'h09, 8'h44);
      for (i = 0; i < 40 && otp_load_req !== 1'b0; i++) tick(1);
      check(8'(i < 40 && n_otp > 0), 8'h01);
      exp_st[4] = otp_ok_in;
      tick(1);
      rd(8'h08, d);
      check(d, exp_st);
    end
    // conversion with the interrupt off leaves the pin idle
    wr(8'h09, 8'h01);
    wait_done(0);
    check(8'({int_out_en, int_out}), 8'h00);
    // reset in mid conversion
    wr(8'h09, 8'h05);
    tick(2);
    reset_n = 1'b0;
    tick(1);
    check(8'({afe_field_convert, int_out_en, int_out}), 8'h00);
    reset_n = 1'b1;
    tick(1);
    rd(8'h08, d);
    check(d, 8'h00);
    end_sim;
  end
endmodule // fsmc_top_tb
